// ===== sow_pkg.sv
// Constants for the system options and wakeup timer block.
// Assumes one bus clock; register index decode is done inside the system control block.
package sow_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // Register indices
  localparam logic [ADDR_W-1:0] IDX_FORCE_RESET = 3'h0;
  localparam logic [ADDR_W-1:0] IDX_OPTIONS = 3'h1;
  localparam logic [ADDR_W-1:0] IDX_ID_HIGH = 3'h2;
  localparam logic [ADDR_W-1:0] IDX_ID_LOW = 3'h3;
  localparam logic [ADDR_W-1:0] IDX_WAKEUP = 3'h4;

  // Force reset register
  localparam int FORCE_BIT = 0;

  // System options fields
  localparam int OPT_WDOG_EN_BIT = 7;
  localparam int OPT_WDOG_LONG_BIT = 6;
  localparam int OPT_STOP_EN_BIT = 5;
  localparam int OPT_DBG_PIN_BIT = 1;
  localparam logic [DATA_W-1:0] OPT_RESET = 8'hc2;
  localparam logic [DATA_W-1:0] OPT_IMPL_MASK = 8'he2;

  // Wakeup control fields
  localparam int WK_FLAG_BIT = 7;
  localparam int WK_ACK_BIT = 6;
  localparam int WK_CLKSEL_BIT = 5;
  localparam int WK_IRQ_EN_BIT = 4;
  localparam int WK_PSEL_LSB = 0;
  localparam int WK_PSEL_W = 3;
  localparam logic WK_CLKSEL_RESET = 1'h0;
  localparam logic WK_IRQ_EN_RESET = 1'h0;
  localparam logic [WK_PSEL_W-1:0] WK_PSEL_RESET = 3'h0;

  // Internal oscillator timing, microseconds
  localparam int INT_OSC_PERIOD_US = 1150;
  localparam int INT_BASE_TIMEOUT_US = 9200;
  localparam int INT_BASE_TICKS = INT_BASE_TIMEOUT_US / INT_OSC_PERIOD_US;

  // External clock dividers per period select code
  localparam int WK_CNT_W = 16;
  localparam logic [WK_CNT_W-1:0] EXT_DIV [8] = '{
    16'h0000, 16'h0100, 16'h0400, 16'h0800,
    16'h1000, 16'h2000, 16'h4000, 16'h8000
  };
endpackage

// ===== sow_wkup_if.sv
// Control and status link between the register bank and wakeup timer.
// Assumes both ends run on the same bus clock.
interface sow_wkup_if;
  logic clk_sel;
  logic [sow_pkg::WK_PSEL_W-1:0] period_sel;
  logic ack;
  logic flag;

  modport ctrl (
    output clk_sel,
    output period_sel,
    output ack,
    input flag
  );

  modport timer (
    input clk_sel,
    input period_sel,
    input ack,
    output flag
  );
endinterface

// ===== sow_wakeup_timer.sv
// Periodic wakeup timer with its sticky flag.
// Assumes both tick sources are slow asynchronous levels.
module sow_wakeup_timer (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_osc_int,
  input wire logic i_clk_ext,
  sow_wkup_if.timer wk
);
  localparam int CW = sow_pkg::WK_CNT_W;
  logic [1:0] src;
  logic [1:0] s1_reg;
  logic [1:0] s2_reg;
  logic [1:0] s3_reg;
  logic [1:0] tick;
  logic sel_tick;
  logic enabled;
  logic hit;
  logic cfg_same;
  logic [CW-1:0] limit;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic [3:0] cfg_reg;
  logic flag_reg;

  assign src = {i_clk_ext, i_osc_int};

  // Two flops before any logic; edge seen only past the second
  genvar g;
  for (g = 0; g < 2; g++) begin : g_sync
    always_ff @(posedge i_clk) begin
      s1_reg[g] <= src[g];
      s2_reg[g] <= s1_reg[g];
      s3_reg[g] <= s2_reg[g];
    end
    assign tick[g] = s2_reg[g] & ~s3_reg[g];
  end

  always_comb begin
    if (wk.clk_sel) begin
      limit = sow_pkg::EXT_DIV[wk.period_sel];
    end else begin
      limit = CW'(sow_pkg::INT_BASE_TICKS) << wk.period_sel;
    end
  end

  assign enabled = !wk.clk_sel || (wk.period_sel != 3'h0);
  assign sel_tick = wk.clk_sel ? tick[1] : tick[0];
  // Old count must not meet a new limit before the restart lands
  assign cfg_same = (cfg_reg == {wk.clk_sel, wk.period_sel});
  assign hit = enabled && cfg_same && sel_tick
    && (cnt_reg == limit - CW'(1));
  assign cnt_next = hit ? '0 : cnt_reg + CW'(1);

  // Restart the count on any source or period change
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cfg_reg <= 4'h0;
      cnt_reg <= '0;
    end else begin
      cfg_reg <= {wk.clk_sel, wk.period_sel};
      if (!enabled || !cfg_same) begin
        cnt_reg <= '0;
      end else if (sel_tick) begin
        cnt_reg <= cnt_next;
      end
    end
  end

  // Set wins over an acknowledge in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      flag_reg <= 1'b0;
    end else if (hit) begin
      flag_reg <= 1'b1;
    end else if (wk.ack) begin
      flag_reg <= 1'b0;
    end
  end
  assign wk.flag = flag_reg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  flag_on_hit_a: assert property (hit |=> wk.flag)
    else $error("wakeup flag not set on timeout");
  ack_clears_a: assert property (wk.ack && !hit |=> !wk.flag)
    else $error("acknowledge did not clear wakeup flag");
  ext_off_a: assert property (wk.clk_sel && wk.period_sel == 3'h0 |-> !hit)
    else $error("external timer ran with period code zero");
  cnt_bound_a: assert property (enabled && cfg_same
    |-> cnt_reg < limit)
    else $error("wakeup counter passed its limit");
endmodule // sow_wakeup_timer

// ===== sow_system_ctrl.sv
// Debug force reset, write-once options, part id and wakeup control.
// Assumes a CPU register port and a debug-command marker on writes.
module sow_system_ctrl #(
  // Arbitrary neutral identification value
  parameter logic [11:0] PART_ID = 12'h05a3
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_osc_int,
  input wire logic i_clk_ext,
  input wire logic [sow_pkg::ADDR_W-1:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [sow_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_debug_cmd,
  input wire logic i_stop_exec,
  output logic [sow_pkg::DATA_W-1:0] o_rdata,
  output logic o_force_reset,
  output logic o_reset_status_clear,
  output logic o_watchdog_enable,
  output logic o_watchdog_long,
  output logic o_stop_enable,
  output logic o_illegal_stop_reset,
  output logic o_debug_pin_enable,
  output logic o_wakeup_irq
);
  localparam int DW = sow_pkg::DATA_W;

  sow_wkup_if wk ();

  logic wr_force;
  logic wr_opt;
  logic wr_wk;
  logic [DW-1:0] opt_reg;
  logic opt_written_reg;
  logic force_reg;
  logic stop_bad_reg;
  logic clk_sel_reg;
  logic irq_en_reg;
  logic [sow_pkg::WK_PSEL_W-1:0] psel_reg;
  logic [DW-1:0] rdata_reg;
  logic [DW-1:0] rdata_next;

  assign wr_force = i_wr && (i_addr == sow_pkg::IDX_FORCE_RESET);
  assign wr_opt = i_wr && (i_addr == sow_pkg::IDX_OPTIONS);
  assign wr_wk = i_wr && (i_addr == sow_pkg::IDX_WAKEUP);

  // Force reset: program writes drop silently, no error path
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      force_reg <= 1'b0;
    end else begin
      force_reg <= wr_force && i_debug_cmd
        && i_wdata[sow_pkg::FORCE_BIT];
    end
  end
  assign o_force_reset = force_reg;
  // Status logic must not record this reset source
  assign o_reset_status_clear = force_reg;

  // Write-once options; a stray late write cannot alter them
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      opt_reg <= sow_pkg::OPT_RESET;
      opt_written_reg <= 1'b0;
    end else if (wr_opt && !opt_written_reg) begin
      opt_reg <= i_wdata & sow_pkg::OPT_IMPL_MASK;
      opt_written_reg <= 1'b1;
    end
  end
  assign o_watchdog_enable = opt_reg[sow_pkg::OPT_WDOG_EN_BIT];
  assign o_watchdog_long = opt_reg[sow_pkg::OPT_WDOG_LONG_BIT];
  assign o_stop_enable = opt_reg[sow_pkg::OPT_STOP_EN_BIT];
  assign o_debug_pin_enable = opt_reg[sow_pkg::OPT_DBG_PIN_BIT];

  // Stop executed while disabled becomes an illegal opcode reset
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      stop_bad_reg <= 1'b0;
    end else begin
      stop_bad_reg <= i_stop_exec && !o_stop_enable;
    end
  end
  assign o_illegal_stop_reset = stop_bad_reg;

  // Wakeup control fields
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      clk_sel_reg <= sow_pkg::WK_CLKSEL_RESET;
      irq_en_reg <= sow_pkg::WK_IRQ_EN_RESET;
      psel_reg <= sow_pkg::WK_PSEL_RESET;
    end else if (wr_wk) begin
      clk_sel_reg <= i_wdata[sow_pkg::WK_CLKSEL_BIT];
      irq_en_reg <= i_wdata[sow_pkg::WK_IRQ_EN_BIT];
      psel_reg <= i_wdata[sow_pkg::WK_PSEL_LSB +: sow_pkg::WK_PSEL_W];
    end
  end
  assign wk.clk_sel = clk_sel_reg;
  assign wk.period_sel = psel_reg;
  // Writing zero to the acknowledge does nothing
  assign wk.ack = wr_wk && i_wdata[sow_pkg::WK_ACK_BIT];

  sow_wakeup_timer u_timer (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_osc_int(i_osc_int),
    .i_clk_ext(i_clk_ext),
    .wk(wk)
  );

  // Level request, dropped only by acknowledge or enable clear
  assign o_wakeup_irq = wk.flag && irq_en_reg;

  // Read mux; unmapped indices return zero
  always_comb begin
    rdata_next = 8'h00;
    case (i_addr)
      sow_pkg::IDX_FORCE_RESET: begin
        rdata_next = 8'h00;
      end
      sow_pkg::IDX_OPTIONS: begin
        rdata_next = opt_reg & sow_pkg::OPT_IMPL_MASK;
      end
      sow_pkg::IDX_ID_HIGH: begin
        rdata_next = {4'h0, PART_ID[11:8]};
      end
      sow_pkg::IDX_ID_LOW: begin
        rdata_next = PART_ID[7:0];
      end
      sow_pkg::IDX_WAKEUP: begin
        rdata_next[sow_pkg::WK_FLAG_BIT] = wk.flag;
        rdata_next[sow_pkg::WK_CLKSEL_BIT] = clk_sel_reg;
        rdata_next[sow_pkg::WK_IRQ_EN_BIT] = irq_en_reg;
        rdata_next[sow_pkg::WK_PSEL_LSB +: sow_pkg::WK_PSEL_W] = psel_reg;
      end
      default: begin
        rdata_next = 8'h00;
      end
    endcase
  end

  // Read data holds until the next read
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rdata_reg <= 8'h00;
    end else if (i_rd) begin
      rdata_reg <= rdata_next;
    end
  end
  assign o_rdata = rdata_reg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  sequence s_user_force;
    wr_force && !i_debug_cmd;
  endsequence

  sequence s_debug_force;
    wr_force && i_debug_cmd && i_wdata[sow_pkg::FORCE_BIT];
  endsequence

  sequence s_first_opt;
    wr_opt && !opt_written_reg;
  endsequence

  sequence s_late_opt;
    wr_opt && opt_written_reg;
  endsequence

  force_user_drop_a: assert property (s_user_force
    |=> !o_force_reset)
    else $error("program write forced a reset");

  force_debug_hit_a: assert property (s_debug_force
    |=> o_force_reset && o_reset_status_clear
    ##1 (!o_force_reset
    || $past(wr_force && i_debug_cmd && i_wdata[sow_pkg::FORCE_BIT])))
    else $error("debug force reset not a single pulse");

  force_read_zero_a: assert property (i_rd
    && i_addr == sow_pkg::IDX_FORCE_RESET |=> o_rdata == 8'h00)
    else $error("force reset register read nonzero");

  opt_first_take_a: assert property (s_first_opt |=>
    o_watchdog_enable == $past(i_wdata[sow_pkg::OPT_WDOG_EN_BIT])
    && o_stop_enable == $past(i_wdata[sow_pkg::OPT_STOP_EN_BIT])
    && o_debug_pin_enable == $past(i_wdata[sow_pkg::OPT_DBG_PIN_BIT]))
    else $error("first options write not taken");

  opt_once_only_a: assert property (s_late_opt |=> $stable(opt_reg))
    else $error("late options write changed settings");

  opt_unimpl_zero_a: assert property (i_rd
    && i_addr == sow_pkg::IDX_OPTIONS |=> o_rdata[3:2] == 2'h0)
    else $error("unimplemented option bits read nonzero");

  opt_reset_dflt_a: assert property ($past(i_srst) |->
    o_watchdog_enable && o_watchdog_long && !o_stop_enable
    && o_debug_pin_enable)
    else $error("options not at reset defaults");

  stop_illegal_a: assert property (i_stop_exec && !o_stop_enable
    |=> o_illegal_stop_reset)
    else $error("disabled stop did not give illegal reset");

  id_read_a: assert property (i_rd && i_addr == sow_pkg::IDX_ID_LOW
    ##1 i_rd && i_addr == sow_pkg::IDX_ID_HIGH
    |=> {o_rdata[3:0], $past(o_rdata)} == PART_ID
    && o_rdata[7:4] == 4'h0)
    else $error("part id bytes wrong");

  ack_read_zero_a: assert property (i_rd
    && i_addr == sow_pkg::IDX_WAKEUP |=> !o_rdata[sow_pkg::WK_ACK_BIT])
    else $error("acknowledge bit read as one");

  irq_gate_a: assert property (!irq_en_reg |-> !o_wakeup_irq)
    else $error("request raised while disabled");

  irq_hold_a: assert property (o_wakeup_irq && !wr_wk
    |=> o_wakeup_irq)
    else $error("request dropped without acknowledge");
endmodule // sow_system_ctrl

// ===== sow_dbg_host.sv
// Debug host model: issues force-reset writes as background commands.
// Assumes the bench raises i_go for one cycle per command.
module sow_dbg_host (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [sow_pkg::DATA_W-1:0] i_data,
  output logic o_wr,
  output logic o_debug_cmd,
  output logic [sow_pkg::ADDR_W-1:0] o_addr,
  output logic [sow_pkg::DATA_W-1:0] o_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_wr = 1'b0;
    o_wdata = 8'h00;
  end
  assign o_addr = sow_pkg::IDX_FORCE_RESET;
  // Only the host marks its writes as debug commands
  assign o_debug_cmd = o_wr;
  always @(negedge i_clk) begin
    o_wr <= i_go;
    // Idle data toggles so a stale value never looks valid
    o_wdata <= i_go ? i_data : ~o_wdata;
  end
endmodule // sow_dbg_host

// ===== system_options_and_wakeup_timer_tb_top.sv
// Self-checking bench for the options, force reset and wakeup timer.
// Assumes sow_pkg and sow_dbg_host are compiled first.
module system_options_and_wakeup_timer_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // Arbitrary neutral identification value
  localparam logic [11:0] PART_ID = 12'h05a3;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_osc_int = 1'b0;
  logic i_clk_ext = 1'b0;
  logic tb_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_stop_exec = 1'b0;
  logic h_go = 1'b0;
  logic h_wr, h_dbg;
  logic [2:0] tb_addr = 3'h0;
  logic [2:0] h_addr;
  logic [7:0] tb_wdata = 8'h00;
  logic [7:0] h_data = 8'h00;
  logic [7:0] h_wdata, o_rdata;
  logic o_force_reset, o_reset_status_clear, o_watchdog_enable;
  logic o_watchdog_long, o_stop_enable, o_illegal_stop_reset;
  logic o_debug_pin_enable, o_wakeup_irq;
  int mismatches = 0;
  int num_checks = 0;

  always #2.5 i_clk = ~i_clk;

  sow_system_ctrl #(.PART_ID(PART_ID)) sow_system_ctrl_i (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_osc_int(i_osc_int),
    .i_clk_ext(i_clk_ext),
    .i_addr(h_wr ? h_addr : tb_addr),
    .i_wr(tb_wr | h_wr),
    .i_rd(i_rd),
    .i_wdata(h_wr ? h_wdata : tb_wdata),
    .i_debug_cmd(h_dbg),
    .i_stop_exec(i_stop_exec),
    .o_rdata(o_rdata),
    .o_force_reset(o_force_reset),
    .o_reset_status_clear(o_reset_status_clear),
    .o_watchdog_enable(o_watchdog_enable),
    .o_watchdog_long(o_watchdog_long),
    .o_stop_enable(o_stop_enable),
    .o_illegal_stop_reset(o_illegal_stop_reset),
    .o_debug_pin_enable(o_debug_pin_enable),
    .o_wakeup_irq(o_wakeup_irq)
  );

  sow_dbg_host sow_dbg_host_i (
    .i_clk(i_clk),
    .i_go(h_go),
    .i_data(h_data),
    .o_wr(h_wr),
    .o_debug_cmd(h_dbg),
    .o_addr(h_addr),
    .o_wdata(h_wdata)
  );

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic do_reset();
    @(negedge i_clk);
    i_srst = 1'b1;
    repeat (10) @(negedge i_clk);
    i_srst = 1'b0;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge i_clk);
    tb_wr = 1'b1;
    tb_addr = a;
    tb_wdata = d;
    @(negedge i_clk);
    tb_wr = 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(negedge i_clk);
    i_rd = 1'b1;
    tb_addr = a;
    @(negedge i_clk);
    i_rd = 1'b0;
    check(o_rdata, e);
  endtask

  // Back-to-back reads, low byte then high byte
  task automatic rd_id_pair();
    @(negedge i_clk);
    i_rd = 1'b1;
    tb_addr = sow_pkg::IDX_ID_LOW;
    @(negedge i_clk);
    check(o_rdata, PART_ID[7:0]);
    tb_addr = sow_pkg::IDX_ID_HIGH;
    @(negedge i_clk);
    i_rd = 1'b0;
    check(o_rdata, {4'h0, PART_ID[11:8]});
  endtask

  task automatic stop_try(input logic e);
    @(negedge i_clk);
    i_stop_exec = 1'b1;
    @(negedge i_clk);
    i_stop_exec = 1'b0;
    check({7'h00, o_illegal_stop_reset}, {7'h00, e});
    @(negedge i_clk);
    check({7'h00, o_illegal_stop_reset}, 8'h00);
  endtask

  task automatic dbg_wr(input logic [7:0] d, input logic e);
    @(negedge i_clk);
    h_go <= 1'b1;
    h_data <= d;
    @(negedge i_clk);
    h_go <= 1'b0;
    @(negedge i_clk);
    check({6'h00, o_force_reset, o_reset_status_clear}, {6'h00, e, e});
    @(negedge i_clk);
    check({6'h00, o_force_reset, o_reset_status_clear}, 8'h00);
  endtask

  // Slow square wave on one source, standing low between bursts
  task automatic pulses(input logic ext, input int n);
    repeat (n) begin
      repeat (10) @(negedge i_clk);
      if (ext) i_clk_ext = 1'b1;
      else i_osc_int = 1'b1;
      repeat (10) @(negedge i_clk);
      if (ext) i_clk_ext = 1'b0;
      else i_osc_int = 1'b0;
    end
    repeat (10) @(negedge i_clk);
  endtask

  function automatic logic [7:0] lv();
    return {4'h0, o_watchdog_enable, o_watchdog_long, o_stop_enable,
      o_debug_pin_enable};
  endfunction

  initial begin
    // Tests need roughly 33k cycles, mostly external tick bursts
    repeat (50000) @(posedge i_clk);
    mismatches++;
    conclude();
  end

  initial begin
    do_reset();
    rd(sow_pkg::IDX_OPTIONS, 8'hc2);
    check(lv(), 8'h0d);
    rd(sow_pkg::IDX_FORCE_RESET, 8'h00);
    rd_id_pair();
    rd(sow_pkg::IDX_WAKEUP, 8'h00);
    rd(3'h7, 8'h00);
    $display("reset values test done");
    wr(sow_pkg::IDX_FORCE_RESET, 8'h01);
    check({6'h00, o_force_reset, o_reset_status_clear}, 8'h00);
    dbg_wr(8'h00, 1'b0);
    dbg_wr(8'h01, 1'b1);
    rd(sow_pkg::IDX_FORCE_RESET, 8'h00);
    stop_try(1'b1);
    $display("force reset test done");
    wr(sow_pkg::IDX_OPTIONS, 8'h20);
    check(lv(), 8'h02);
    rd(sow_pkg::IDX_OPTIONS, 8'h20);
    wr(sow_pkg::IDX_OPTIONS, 8'hff);
    rd(sow_pkg::IDX_OPTIONS, 8'h20);
    stop_try(1'b0);
    do_reset();
    rd(sow_pkg::IDX_OPTIONS, 8'hc2);
    wr(sow_pkg::IDX_OPTIONS, 8'hc2);
    wr(sow_pkg::IDX_OPTIONS, 8'h00);
    rd(sow_pkg::IDX_OPTIONS, 8'hc2);
    $display("options test done");
    wr(sow_pkg::IDX_WAKEUP, 8'h10);
    pulses(1'b0, 7);
    rd(sow_pkg::IDX_WAKEUP, 8'h10);
    pulses(1'b0, 1);
    rd(sow_pkg::IDX_WAKEUP, 8'h90);
    check({7'h00, o_wakeup_irq}, 8'h01);
    wr(sow_pkg::IDX_WAKEUP, 8'h10);
    rd(sow_pkg::IDX_WAKEUP, 8'h90);
    wr(sow_pkg::IDX_WAKEUP, 8'h50);
    rd(sow_pkg::IDX_WAKEUP, 8'h10);
    check({7'h00, o_wakeup_irq}, 8'h00);
    wr(sow_pkg::IDX_WAKEUP, 8'h00);
    pulses(1'b0, 8);
    rd(sow_pkg::IDX_WAKEUP, 8'h80);
    check({7'h00, o_wakeup_irq}, 8'h00);
    wr(sow_pkg::IDX_WAKEUP, 8'h40);
    rd(sow_pkg::IDX_WAKEUP, 8'h00);
    wr(sow_pkg::IDX_WAKEUP, 8'h01);
    pulses(1'b0, 15);
    rd(sow_pkg::IDX_WAKEUP, 8'h01);
    pulses(1'b0, 1);
    rd(sow_pkg::IDX_WAKEUP, 8'h81);
    wr(sow_pkg::IDX_WAKEUP, 8'h40);
    $display("internal wakeup test done");
    wr(sow_pkg::IDX_WAKEUP, 8'h21);
    pulses(1'b0, 8);
    rd(sow_pkg::IDX_WAKEUP, 8'h21);
    pulses(1'b1, 255);
    rd(sow_pkg::IDX_WAKEUP, 8'h21);
    pulses(1'b1, 1);
    rd(sow_pkg::IDX_WAKEUP, 8'ha1);
    wr(sow_pkg::IDX_WAKEUP, 8'h60);
    pulses(1'b1, 300);
    rd(sow_pkg::IDX_WAKEUP, 8'h20);
    wr(sow_pkg::IDX_WAKEUP, 8'h22);
    pulses(1'b1, 1023);
    rd(sow_pkg::IDX_WAKEUP, 8'h22);
    pulses(1'b1, 1);
    rd(sow_pkg::IDX_WAKEUP, 8'ha2);
    $display("external wakeup test done");
    conclude();
  end
endmodule // system_options_and_wakeup_timer_tb_top
